// *** rtl/cxm_matrix_dev.sv ***
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cxm_matrix_dev (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  sclr,
  input  wire logic [3*cxm_pkg::IN_W-1:0] video_data_in,
  input  wire logic                  hblank_in,
  input  wire logic                  vblank_in,
  input  wire logic                  active_video_in,
  output logic [3*cxm_pkg::output_channel_width-1:0] video_data_out,
  output logic                       hblank_out,
  output logic                       vblank_out,
  output logic                       active_video_out,
  cxm_if.dev                         link
);
  localparam int IW  = cxm_pkg::IN_W;
  localparam int OCW = cxm_pkg::output_channel_width;
  localparam int SW  = cxm_pkg::SUM_W;
  localparam int PW  = cxm_pkg::PROD_W;
  localparam int FR  = cxm_pkg::COEF_FRAC;
  localparam int LAT = cxm_pkg::LATENCY;
  localparam int DW  = 3 * IW + 3;  // raw data plus three syncs

  cxm_pkg::cxm_coef_t        coef_in   [9];  // ports, row-major
  cxm_pkg::cxm_ofs_t         ofs_in    [3];
  cxm_pkg::cxm_coef_t        port_coef [9];  // port registers
  cxm_pkg::cxm_ofs_t         port_ofs  [3];
  logic [cxm_pkg::CTRL_W-1:0] port_ctrl;
  cxm_pkg::cxm_coef_t        work_coef [9];  // working set
  cxm_pkg::cxm_ofs_t         work_ofs  [3];
  logic                      work_en;        // matrix applied
  logic                      vblank_q;       // last sampled vblank
  logic                      vblank_rise;
  logic                      load_set;       // copy into working set
  logic [DW-1:0]             dly [LAT];      // sync and raw data line
  logic [IW-1:0]             s1_px   [3];    // stage 1 pixels r,g,b
  logic signed [PW-1:0]      s2_prod [9];    // stage 2 products
  logic signed [SW-1:0]      s3_sum  [3];    // stage 3 row sums
  logic [3*OCW-1:0]          s4_bus;         // stage 4 clamped
  logic [3*OCW-1:0]          next_s4_bus;
  logic [3*OCW-1:0]          tail [LAT-4];   // stages 5 to 7

  // unpack the port bundle
  assign coef_in[0] = link.coef_row1_col1;
  assign coef_in[1] = link.coef_row1_col2;
  assign coef_in[2] = link.coef_row1_col3;
  assign coef_in[3] = link.coef_row2_col1;
  assign coef_in[4] = link.coef_row2_col2;
  assign coef_in[5] = link.coef_row2_col3;
  assign coef_in[6] = link.coef_row3_col1;
  assign coef_in[7] = link.coef_row3_col2;
  assign coef_in[8] = link.coef_row3_col3;
  assign ofs_in[0]  = link.offset_red;
  assign ofs_in[1]  = link.offset_green;
  assign ofs_in[2]  = link.offset_blue;

  // frame end: rising vblank as sampled under ce
  assign vblank_rise = vblank_in & ~vblank_q;
  // load only when the semaphore is up at that edge
  assign load_set = ce & vblank_rise
                  & port_ctrl[cxm_pkg::CTRL_UPD];

  // vblank history for edge detection
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vblank_q <= 1'b0;
    end else if (sclr) begin
      vblank_q <= 1'b0;
    end else if (ce) begin
      vblank_q <= vblank_in;
    end
  end

  // port registers follow the ports every enabled cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      port_ctrl <= cxm_pkg::CTRL_RST;
      for (int i = 0; i < 9; i++) begin
        port_coef[i] <= (i % 4 == 0) ? cxm_pkg::COEF_RST_DIA
                                     : cxm_pkg::COEF_RST_OFF;
      end
      for (int i = 0; i < 3; i++) begin
        port_ofs[i] <= cxm_pkg::OFS_RST;
      end
    end else if (sclr) begin
      port_ctrl <= cxm_pkg::CTRL_RST;
      for (int i = 0; i < 9; i++) begin
        port_coef[i] <= (i % 4 == 0) ? cxm_pkg::COEF_RST_DIA
                                     : cxm_pkg::COEF_RST_OFF;
      end
      for (int i = 0; i < 3; i++) begin
        port_ofs[i] <= cxm_pkg::OFS_RST;
      end
    end else if (ce) begin
      port_ctrl <= link.control;
      for (int i = 0; i < 9; i++) begin
        port_coef[i] <= coef_in[i];
      end
      for (int i = 0; i < 3; i++) begin
        port_ofs[i] <= ofs_in[i];
      end
    end
  end

  // working set changes only at a frame boundary, so no tearing
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 9; i++) begin
        work_coef[i] <= (i % 4 == 0) ? cxm_pkg::COEF_RST_DIA
                                     : cxm_pkg::COEF_RST_OFF;
      end
      for (int i = 0; i < 3; i++) begin
        work_ofs[i] <= cxm_pkg::OFS_RST;
      end
    end else if (sclr) begin
      for (int i = 0; i < 9; i++) begin
        work_coef[i] <= (i % 4 == 0) ? cxm_pkg::COEF_RST_DIA
                                     : cxm_pkg::COEF_RST_OFF;
      end
      for (int i = 0; i < 3; i++) begin
        work_ofs[i] <= cxm_pkg::OFS_RST;
      end
    end else if (load_set) begin
      for (int i = 0; i < 9; i++) begin
        work_coef[i] <= port_coef[i];
      end
      for (int i = 0; i < 3; i++) begin
        work_ofs[i] <= port_ofs[i];
      end
    end
  end

  // enable follows software at every frame end, no semaphore
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      work_en <= 1'b0;
    end else if (sclr) begin
      work_en <= 1'b0;
    end else if (ce && vblank_rise) begin
      work_en <= port_ctrl[cxm_pkg::CTRL_EN];
    end
  end

  // tell the controller its stored set was taken
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      link.update_taken <= 1'b0;
    end else if (sclr) begin
      link.update_taken <= 1'b0;
    end else begin
      link.update_taken <= load_set;
    end
  end

  // delay line for syncs and bypass data, seven deep
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < LAT; k++) begin
        dly[k] <= '0;
      end
    end else if (sclr) begin
      for (int k = 0; k < LAT; k++) begin
        dly[k] <= '0;
      end
    end else if (ce) begin
      dly[0] <= {hblank_in, vblank_in, active_video_in, video_data_in};
      for (int k = 1; k < LAT; k++) begin
        dly[k] <= dly[k-1];
      end
    end
  end

  // per channel: input slice, weighted row sum with offset
  for (genvar c = 0; c < 3; c++) begin : g_chan
    localparam int LANE = (c == 0) ? cxm_pkg::LANE_R :
                          (c == 1) ? cxm_pkg::LANE_G : cxm_pkg::LANE_B;
    // stage 1: pick this channel out of the bus
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        s1_px[c] <= '0;
      end else if (sclr) begin
        s1_px[c] <= '0;
      end else if (ce) begin
        s1_px[c] <= video_data_in[LANE*IW +: IW];
      end
    end
    // stage 2: column c of every row times pixel c
    // fixed indices keep each channel's products in its own process;
    // operands widen first so the product is never cut to 18 bits
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        s2_prod[c]   <= '0;
        s2_prod[c+3] <= '0;
        s2_prod[c+6] <= '0;
      end else if (sclr) begin
        s2_prod[c]   <= '0;
        s2_prod[c+3] <= '0;
        s2_prod[c+6] <= '0;
      end else if (ce) begin
        s2_prod[c]   <= PW'(work_coef[c]) * PW'($signed({1'b0, s1_px[c]}));
        s2_prod[c+3] <= PW'(work_coef[c+3]) * PW'($signed({1'b0, s1_px[c]}));
        s2_prod[c+6] <= PW'(work_coef[c+6]) * PW'($signed({1'b0, s1_px[c]}));
      end
    end
    // stage 3: row c sum, offset scaled to the fraction, rounding
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        s3_sum[c] <= '0;
      end else if (sclr) begin
        s3_sum[c] <= '0;
      end else if (ce) begin
        s3_sum[c] <= SW'(s2_prod[c*3]) + SW'(s2_prod[c*3+1])
                   + SW'(s2_prod[c*3+2])
                   + (SW'(work_ofs[c]) <<< FR)
                   + cxm_pkg::ROUND_HALF;
      end
    end
    // clamp to the output range; bypass when disabled
    always_comb begin
      next_s4_bus[LANE*OCW +: OCW] =
        dly[cxm_pkg::CALC_DLY-1][LANE*IW +: IW];
      if (work_en) begin
        if (s3_sum[c] < 0) begin
          next_s4_bus[LANE*OCW +: OCW] = '0;
        end else if ((s3_sum[c] >>> FR) > SW'(cxm_pkg::PIX_MAX)) begin
          next_s4_bus[LANE*OCW +: OCW] = cxm_pkg::PIX_MAX;
        end else begin
          next_s4_bus[LANE*OCW +: OCW] = s3_sum[c][FR +: OCW];
        end
      end
    end
  end

  // stages 4 to 7: clamp result then pad to the fixed latency
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s4_bus <= '0;
      for (int k = 0; k < LAT - 4; k++) begin
        tail[k] <= '0;
      end
    end else if (sclr) begin
      s4_bus <= '0;
      for (int k = 0; k < LAT - 4; k++) begin
        tail[k] <= '0;
      end
    end else if (ce) begin
      s4_bus  <= next_s4_bus;
      tail[0] <= s4_bus;
      for (int k = 1; k < LAT - 4; k++) begin
        tail[k] <= tail[k-1];
      end
    end
  end

  // outputs straight from the last stage flops
  assign video_data_out   = tail[LAT-5];
  assign hblank_out       = dly[LAT-1][3*IW+2];
  assign vblank_out       = dly[LAT-1][3*IW+1];
  assign active_video_out = dly[LAT-1][3*IW];
endmodule
`default_nettype wire

// *** rtl/cxm_pkg.sv ***
package cxm_pkg;
  // channel widths
  localparam int IN_W                 = 8;
  localparam int output_channel_width = 8;
  localparam int CHANNELS             = 3;
  localparam int COEFS                = CHANNELS * CHANNELS;
  // coefficient format: signed 18 bits, 15 fraction bits
  localparam int COEF_W    = 18;
  localparam int COEF_FRAC = 15;
  // offsets one bit wider than an output channel
  localparam int OFS_W     = output_channel_width + 1;
  // product and accumulator widths
  localparam int PROD_W    = COEF_W + IN_W + 1;
  localparam int SUM_W     = PROD_W + 3;
  localparam logic signed [SUM_W-1:0] ROUND_HALF = 30'h0000_4000;
  localparam logic [output_channel_width-1:0] PIX_MAX = 8'hff;
  // control word layout
  localparam int CTRL_W   = 2;
  localparam int CTRL_EN  = 0;
  localparam int CTRL_UPD = 1;
  // bus lane of each channel (red, green, blue)
  localparam int LANE_R = 2;
  localparam int LANE_G = 0;
  localparam int LANE_B = 1;
  // processing latency in clock cycles
  localparam int LATENCY  = 7;
  localparam int CALC_DLY = 3;
  // reset values: identity matrix, zero offsets
  localparam logic [CTRL_W-1:0] CTRL_RST     = 2'h0;
  localparam logic [COEF_W-1:0] COEF_RST_DIA = 18'h08000;
  localparam logic [COEF_W-1:0] COEF_RST_OFF = 18'h00000;
  localparam logic [OFS_W-1:0]  OFS_RST      = 9'h000;
  // controller register word indices (byte address = 4 * index)
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_COEF0  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_OFS0   = 4'ha;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hd;
  localparam int CNT_W = 16;
  typedef logic signed [COEF_W-1:0] cxm_coef_t;
  typedef logic signed [OFS_W-1:0]  cxm_ofs_t;
endpackage

// *** rtl/cxm_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// coefficient port bundle between controller and matrix
interface cxm_if;
  logic [cxm_pkg::CTRL_W-1:0] control;        // enable, update semaphore
  cxm_pkg::cxm_coef_t         coef_row1_col1;
  cxm_pkg::cxm_coef_t         coef_row1_col2;
  cxm_pkg::cxm_coef_t         coef_row1_col3;
  cxm_pkg::cxm_coef_t         coef_row2_col1;
  cxm_pkg::cxm_coef_t         coef_row2_col2;
  cxm_pkg::cxm_coef_t         coef_row2_col3;
  cxm_pkg::cxm_coef_t         coef_row3_col1;
  cxm_pkg::cxm_coef_t         coef_row3_col2;
  cxm_pkg::cxm_coef_t         coef_row3_col3;
  cxm_pkg::cxm_ofs_t          offset_red;
  cxm_pkg::cxm_ofs_t          offset_green;
  cxm_pkg::cxm_ofs_t          offset_blue;
  logic                       update_taken;   // one-cycle pulse per load
  // matrix end reads the ports, reports loads
  modport dev (
    input  control, offset_red, offset_green, offset_blue,
    input  coef_row1_col1, coef_row1_col2, coef_row1_col3,
    input  coef_row2_col1, coef_row2_col2, coef_row2_col3,
    input  coef_row3_col1, coef_row3_col2, coef_row3_col3,
    output update_taken
  );
  // controller end drives the ports
  modport ctl (
    output control, offset_red, offset_green, offset_blue,
    output coef_row1_col1, coef_row1_col2, coef_row1_col3,
    output coef_row2_col1, coef_row2_col2, coef_row2_col3,
    output coef_row3_col1, coef_row3_col2, coef_row3_col3,
    input  update_taken
  );
endinterface
`default_nettype wire

// *** rtl/cxm_coef_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
// controller end: avalon-mm slave holding the coefficient ports
module cxm_coef_ctl (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [cxm_pkg::ADDR_W-1:0]  address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [cxm_pkg::DATA_W-1:0]  writedata,
  output logic      [cxm_pkg::DATA_W-1:0]  readdata,
  output logic                             waitrequest,
  cxm_if.ctl                               link
);
  localparam int CW = cxm_pkg::COEF_W;
  localparam int OW = cxm_pkg::OFS_W;

  logic [cxm_pkg::CTRL_W-1:0] ctrl;        // enable and semaphore
  cxm_pkg::cxm_coef_t         coef [9];    // row-major coefficients
  cxm_pkg::cxm_ofs_t          ofs  [3];    // red, green, blue offsets
  logic [cxm_pkg::CNT_W-1:0]  load_count;  // loads seen since reset
  logic [cxm_pkg::DATA_W-1:0] next_readdata;
  logic                       wr_go;       // write completes this edge
  logic                       coef_open;   // stored set may change
  logic [cxm_pkg::ADDR_W-1:0] coef_idx;
  logic [cxm_pkg::ADDR_W-1:0] ofs_idx;

  assign wr_go     = write & ~waitrequest;
  assign coef_open = ~ctrl[cxm_pkg::CTRL_UPD];
  assign coef_idx  = address - cxm_pkg::REG_COEF0;
  assign ofs_idx   = address - cxm_pkg::REG_OFS0;

  // one wait state, then answer; idle waitrequest stays high
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if ((read | write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= next_readdata;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // read mux; narrow fields sit in the low bits, the status load count in the top 16, rest zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (address == cxm_pkg::REG_CTRL) begin
      next_readdata[cxm_pkg::CTRL_W-1:0] = ctrl;
    end else if (address >= cxm_pkg::REG_COEF0 &&
                 address <  cxm_pkg::REG_OFS0) begin
      next_readdata[CW-1:0] = coef[coef_idx];
    end else if (address >= cxm_pkg::REG_OFS0 &&
                 address <  cxm_pkg::REG_STATUS) begin
      next_readdata[OW-1:0] = ofs[ofs_idx[1:0]];
    end else if (address == cxm_pkg::REG_STATUS) begin
      next_readdata[0] = ctrl[cxm_pkg::CTRL_UPD];
      next_readdata[cxm_pkg::DATA_W-1:cxm_pkg::DATA_W-cxm_pkg::CNT_W]
        = load_count;
    end
  end

  // control word; a software write wins over the auto clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= cxm_pkg::CTRL_RST;
    end else begin
      if (link.update_taken) begin
        ctrl[cxm_pkg::CTRL_UPD] <= 1'b0;  // semaphore done
      end
      if (wr_go && address == cxm_pkg::REG_CTRL) begin
        ctrl <= writedata[cxm_pkg::CTRL_W-1:0];
      end
    end
  end

  // stored set changes only while no update is pending
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 9; i++) begin
        coef[i] <= (i % 4 == 0) ? cxm_pkg::COEF_RST_DIA
                                : cxm_pkg::COEF_RST_OFF;
      end
      for (int i = 0; i < 3; i++) begin
        ofs[i] <= cxm_pkg::OFS_RST;
      end
    end else if (wr_go && coef_open) begin
      if (address >= cxm_pkg::REG_COEF0 &&
          address <  cxm_pkg::REG_OFS0) begin
        coef[coef_idx] <= writedata[CW-1:0];
      end else if (address >= cxm_pkg::REG_OFS0 &&
                   address <  cxm_pkg::REG_STATUS) begin
        ofs[ofs_idx[1:0]] <= writedata[OW-1:0];
      end
    end
  end

  // count loads so software can see frames pass
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      load_count <= 16'h0000;
    end else if (link.update_taken) begin
      load_count <= load_count + 16'h0001;
    end
  end

  // drive the port bundle straight from the registers
  assign link.control        = ctrl;
  assign link.coef_row1_col1 = coef[0];
  assign link.coef_row1_col2 = coef[1];
  assign link.coef_row1_col3 = coef[2];
  assign link.coef_row2_col1 = coef[3];
  assign link.coef_row2_col2 = coef[4];
  assign link.coef_row2_col3 = coef[5];
  assign link.coef_row3_col1 = coef[6];
  assign link.coef_row3_col2 = coef[7];
  assign link.coef_row3_col3 = coef[8];
  assign link.offset_red     = ofs[0];
  assign link.offset_green   = ofs[1];
  assign link.offset_blue    = ofs[2];
endmodule
`default_nettype wire

// *** tb/cxm_link_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// link checks between controller and matrix ends
module cxm_link_assertions (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic [cxm_pkg::CTRL_W-1:0] control,
  input wire cxm_pkg::cxm_coef_t         coef_row1_col1,
  input wire cxm_pkg::cxm_coef_t         coef_row1_col2,
  input wire cxm_pkg::cxm_coef_t         coef_row1_col3,
  input wire cxm_pkg::cxm_coef_t         coef_row2_col1,
  input wire cxm_pkg::cxm_coef_t         coef_row2_col2,
  input wire cxm_pkg::cxm_coef_t         coef_row2_col3,
  input wire cxm_pkg::cxm_coef_t         coef_row3_col1,
  input wire cxm_pkg::cxm_coef_t         coef_row3_col2,
  input wire cxm_pkg::cxm_coef_t         coef_row3_col3,
  input wire cxm_pkg::cxm_ofs_t          offset_red,
  input wire cxm_pkg::cxm_ofs_t          offset_green,
  input wire cxm_pkg::cxm_ofs_t          offset_blue,
  input wire logic                       update_taken
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic                                         upd;  // semaphore bit
  logic [9*cxm_pkg::COEF_W+3*cxm_pkg::OFS_W-1:0] pset; // whole port set
  assign upd  = control[cxm_pkg::CTRL_UPD];
  assign pset = {coef_row1_col1, coef_row1_col2, coef_row1_col3,
                 coef_row2_col1, coef_row2_col2, coef_row2_col3,
                 coef_row3_col1, coef_row3_col2, coef_row3_col3,
                 offset_red, offset_green, offset_blue};
  // semaphore raised, and semaphore gone again
  sequence sem_rise;
    $rose(upd);
  endsequence
  sequence sem_drop;
    !upd;
  endsequence
  chk_set_frozen: assert property (upd |=> $stable(pset))
    else $error("port set changed while load pending");
  chk_taken_sem: assert property (
    update_taken |-> upd && $past(upd, 2))
    else $error("load without semaphore");
  chk_sem_clear: assert property (update_taken |=> sem_drop)
    else $error("semaphore not cleared after load");
  chk_taken_pulse: assert property (update_taken |=> !update_taken)
    else $error("load pulse longer than one cycle");
  chk_sem_hold: assert property (sem_rise |-> upd [*3])
    else $error("semaphore dropped before load");
  chk_no_early: assert property (sem_rise |-> !update_taken [*2])
    else $error("load too soon after semaphore");
  chk_idle_quiet: assert property (
    !upd && !$past(upd) |-> !update_taken)
    else $error("load while semaphore clear");
  chk_reset_set: assert property ($rose(resetn) |->
    control == cxm_pkg::CTRL_RST && coef_row1_col1 == cxm_pkg::COEF_RST_DIA &&
    coef_row1_col2 == cxm_pkg::COEF_RST_OFF && offset_red == cxm_pkg::OFS_RST)
    else $error("port set not at reset values");
endmodule
`default_nettype wire

// *** tb/color_matrix_coeff_update_ports_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module color_matrix_coeff_update_ports_tb_top;
  logic               clock, resetn, ce, sclr;
  logic               read, write, waitrequest;   // avalon handshake
  logic [3:0]         address;
  logic [31:0]        writedata, readdata;
  logic               hbi, vbi, avi, hbo, vbo, avo; // video flags
  logic [23:0]        vdi, vdo;                     // pixel in, out
  logic               ce_prev, en_w;                // ce last edge, enable
  logic [1:0]         ctl_w;                        // control as written
  int                 err_count, check_count, seed;
  logic [31:0]        rd_q[$];                      // expected reads
  logic [25:0]        px_q[$];                      // expected {hb,vb,px}
  cxm_pkg::cxm_coef_t k[9], kw[9];                  // written, working
  cxm_pkg::cxm_ofs_t  o[3], ow[3];
  cxm_if lnk ();
  cxm_coef_ctl u_cxm_coef_ctl (.clock(clock), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .link(lnk));
  cxm_matrix_dev u_cxm_matrix_dev (.clock(clock), .resetn(resetn), .ce(ce),
    .sclr(sclr), .video_data_in(vdi), .hblank_in(hbi), .vblank_in(vbi),
    .active_video_in(avi), .video_data_out(vdo), .hblank_out(hbo),
    .vblank_out(vbo), .active_video_out(avo), .link(lnk));
  cxm_link_assertions u_cxm_link_assertions (.clock(clock), .resetn(resetn),
    .control(lnk.control), .update_taken(lnk.update_taken),
    .coef_row1_col1(lnk.coef_row1_col1), .coef_row1_col2(lnk.coef_row1_col2),
    .coef_row1_col3(lnk.coef_row1_col3), .coef_row2_col1(lnk.coef_row2_col1),
    .coef_row2_col2(lnk.coef_row2_col2), .coef_row2_col3(lnk.coef_row2_col3),
    .coef_row3_col1(lnk.coef_row3_col1), .coef_row3_col2(lnk.coef_row3_col2),
    .coef_row3_col3(lnk.coef_row3_col3), .offset_red(lnk.offset_red),
    .offset_green(lnk.offset_green), .offset_blue(lnk.offset_blue));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // working set back to identity, as after reset or clear
  task automatic reset_model();
    foreach (kw[i]) kw[i] = (i % 4 == 0) ? cxm_pkg::COEF_RST_DIA : 18'h0;
    foreach (ow[i]) ow[i] = 9'h000;
    en_w = 1'b0;
  endtask
  // own model: row sum, round half up, offset, clamp
  function automatic logic [23:0] expect_px(logic [23:0] p);
    logic signed [31:0] s;
    logic [7:0]         c[3];  // red, green, blue
    logic [7:0]         r[3];
    c = '{p[23:16], p[7:0], p[15:8]};
    for (int i = 0; i < 3; i++) begin
      s = kw[3*i] * $signed({1'b0, c[0]}) + kw[3*i+1] * $signed({1'b0, c[1]})
        + kw[3*i+2] * $signed({1'b0, c[2]}) + 32'sh4000;
      s = (s >>> 15) + ow[i];
      r[i] = !en_w ? c[i] : (s < 0) ? 8'h00 : (s > 255) ? 8'hff : s[7:0];
    end
    return {r[0], r[2], r[1]};
  endfunction
  // one avalon access, held until waitrequest is seen low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    int t;
    @(posedge clock);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    t = 0;
    // no local limit: only the watchdog ends a stuck wait
    do begin
      @(posedge clock);
      t++;
    end while (waitrequest !== 1'b0);
    check("wait states", 32'(t), 32'h2);
    write <= 1'b0;
    read  <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  // pixels; with rnd_ce the unsampled cycles carry junk
  task automatic send_px(int n, bit rnd_ce);
    logic [23:0] p;
    logic        c;
    int          i;
    i = 0;
    while (i < n) begin
      p = $random(seed);
      c = rnd_ce ? 1'($random(seed)) : 1'b1;
      @(posedge clock);
      ce  <= c;
      vdi <= p;
      hbi <= p[0];
      avi <= 1'b1;
      if (c) begin
        px_q.push_back({p[0], 1'b0, expect_px(p)});
        i++;
      end
    end
    @(posedge clock);
    avi <= 1'b0;
    ce  <= 1'b1;
    repeat (12) @(posedge clock);
  endtask
  // vertical blank rise: enable always, set only if pending
  task automatic frame_edge();
    @(posedge clock);
    vbi <= 1'b1;
    en_w = ctl_w[0];
    if (ctl_w[1]) begin
      kw = k;
      ow = o;
      ctl_w[1] = 1'b0;
    end
    repeat (4) @(posedge clock);
    vbi <= 1'b0;
  endtask
  // read results
  always @(posedge clock)
    if (read === 1'b1 && waitrequest === 1'b0)
      check("readdata", readdata, rd_q.pop_front());
  // pixel results, only after an edge that moved the pipe
  always @(posedge clock) begin
    if (ce_prev === 1'b1 && avo === 1'b1)
      check("pixel", {6'h0, hbo, vbo, vdo}, {6'h0, px_q.pop_front()});
    ce_prev = ce;
  end
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
  initial begin
    {resetn, read, write, sclr, hbi, vbi, avi} = 7'h00;
    {address, writedata, vdi, ce_prev} = 61'h0;
    ce = 1'b1;
    ctl_w = 2'h0;
    seed = 78;
    reset_model();
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    // reset values, status and unmapped words
    bus(1'b1, 4'hf, 32'h1234_5678);
    for (int a = 0; a < 16; a++)
      rd(4'(a), (a == 1 || a == 5 || a == 9) ? 32'h8000 : 32'h0);
    $display("test reset values done");
    // latency of one lone pixel
    @(posedge clock);
    vdi <= 24'h5a_c3_81;
    avi <= 1'b1;
    px_q.push_back({2'b00, expect_px(24'h5a_c3_81)});
    @(posedge clock);
    avi <= 1'b0;
    repeat (5) @(posedge clock);
    #1 check("latency early", 32'(avo), 32'h0);
    @(posedge clock);
    #1 check("latency", 32'(avo), 32'h1);
    send_px(8, 1'b1);
    $display("test latency and freeze done");
    // program a set; it waits for the frame edge
    foreach (k[i]) k[i] = 18'($random(seed) % 65536);
    o = '{9'h100, 9'h0ff, 9'($random(seed))};
    foreach (k[i]) bus(1'b1, cxm_pkg::REG_COEF0 + 4'(i), {14'h0, k[i]});
    foreach (o[i]) bus(1'b1, cxm_pkg::REG_OFS0 + 4'(i), {23'h0, o[i]});
    ctl_w = 2'h3;
    bus(1'b1, cxm_pkg::REG_CTRL, 32'h3);
    bus(1'b1, cxm_pkg::REG_COEF0, 32'h0_1234); // refused while pending
    rd(cxm_pkg::REG_COEF0, {14'h0, k[0]});
    rd(cxm_pkg::REG_OFS0, {23'h0, o[0]});
    rd(cxm_pkg::REG_STATUS, 32'h1);
    send_px(6, 1'b0);
    frame_edge();
    rd(cxm_pkg::REG_CTRL, 32'h1);
    rd(cxm_pkg::REG_STATUS, 32'h0001_0000);
    send_px(24, 1'b1);
    $display("test semaphore load done");
    // enable off alone: pass-through
    ctl_w = 2'h0;
    bus(1'b1, cxm_pkg::REG_CTRL, 32'h0);
    frame_edge();
    send_px(8, 1'b1);
    $display("test enable off done");
    // clear while ce is low
    @(posedge clock);
    sclr <= 1'b1;
    ce   <= 1'b0;
    @(posedge clock);
    sclr <= 1'b0;
    ce   <= 1'b1;
    #1 check("cleared pixel", {8'h0, vdo}, 32'h0);
    reset_model();
    ctl_w = 2'h1;
    bus(1'b1, cxm_pkg::REG_CTRL, 32'h1);
    frame_edge();
    send_px(8, 1'b1);
    ctl_w = 2'h3;
    bus(1'b1, cxm_pkg::REG_CTRL, 32'h3);
    frame_edge();
    send_px(16, 1'b1);
    $display("test clear and reload done");
    complete_run();
  end
endmodule
`default_nettype wire
